// File: hdl/acs_sequencer.v
// Calibration sequencer for a three-core interleaved converter with an AXI4-Lite slave.
//
// Behaviour
// - Foreground calibration takes all cores offline and forces output to mid-code zero.
// - Six banks form three two-way interleaved cores A, B and C.
// - Foreground: A samples input A, B samples input B, or both one input.
// - Background mode periodically substitutes core C for core A or B.
// - Spare is calibrated first, relieves an active core, rotation repeats.
// - Each calibration adjusts linearity, gain and offset of both banks of each core it calibrates.
// - Trim fields reset to factory values and are readable and writable.
// - Foreground calibration runs after power-up; host waits before programming.
// - Foreground calibration starts from pin or software trigger, chosen by select bit.
// - Brief glitches when cores swap in background mode are tolerated.
// - With low power enabled, offline cores stay powered down until due.
// - Sleep interval sets spare sleep time when low power on and manual off.
// - Settle interval sets how long a woken core stabilises before calibration.
// - Manual switch bit selects automatic or trigger-driven core switching.
// - Foreground offset enable calibrates buffer offsets once per foreground calibration.
// - Background offset enable keeps correcting buffer offsets in the background routine.
// - Foreground offset enable set before calibration enable gives one-time offset run.
// - Offset calibration writes offset trims; software must not write them then.
`timescale 1ns/1ps
`include "acs_consts.vh"
module acs_sequencer #(
	parameter CAL_CYCLES = (`ACS_CAL_TIME_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
	parameter OFS_CYCLES = (`ACS_OFS_TIME_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS,
	parameter [7:0] FACTORY_TRIM = `ACS_TRIM_DEFAULT
) (
	input wire clk,
	input wire rst_n,
	input wire calibration_pin_trigger,
	input wire [7:0] sample_core_a,
	input wire [7:0] sample_core_b,
	input wire [7:0] sample_core_c,
	input wire [7:0] ofs_estimate,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg [7:0] data_out_a,
	output reg [7:0] data_out_b,
	output reg [2:0] core_online,
	output reg [2:0] core_powered,
	output reg [2:0] core_calibrating,
	output reg [1:0] core_c_stands_for,
	output reg [1:0] core_a_input,
	output reg [1:0] core_b_input,
	output reg offset_cal_active
);
	localparam S_FG = 7'b0000001;
	localparam S_FG_OFS = 7'b0000010;
	localparam S_IDLE = 7'b0000100;
	localparam S_SLEEP = 7'b0001000;
	localparam S_SETTLE = 7'b0010000;
	localparam S_BG_CAL = 7'b0100000;
	localparam S_WAIT_SW = 7'b1000000;

	reg [31:0] ctrl;
	reg [31:0] lp;
	reg [6:0] state;
	reg [31:0] count;
	reg [1:0] swap_target;
	reg foreground_complete_flag;
	reg fg_ofs_pending;
	reg cal_en_q;
	reg pin_s1, pin_s2, pin_s3;
	reg soft_pulse;
	wire [47:0] input_offset_trim;
	reg [31:0] wr_addr;
	reg [31:0] wr_data;
	reg [3:0] wr_strb;
	reg have_aw, have_w;

	wire trigger_source_select = ctrl[`ACS_CTRL_TRIG_SRC];
	wire background_mode_enable = ctrl[`ACS_CTRL_BG];
	wire low_power_spare_enable = ctrl[`ACS_CTRL_LOW_POWER_SPARE_ENABLE];
	wire spare_manual_switch = ctrl[`ACS_CTRL_MANUAL];
	wire foreground_offset_enable = ctrl[`ACS_CTRL_FG_OFS];
	wire background_offset_enable = ctrl[`ACS_CTRL_BG_OFS];
	wire low_power_background_mode = background_mode_enable & low_power_spare_enable;
	wire [15:0] spare_sleep_interval = lp[15:0];
	wire [15:0] spare_settle_interval = lp[31:16];
	wire pin_rise = pin_s2 & ~pin_s3;
	wire trigger = trigger_source_select ? pin_rise : soft_pulse;
	wire any_ofs = foreground_offset_enable | background_offset_enable;
	wire wr_fire = have_aw & have_w & ~s_axi_bvalid;
	wire wr_ofs_hit = wr_addr[7:0] >= `ACS_REG_OFS_BASE && wr_addr[7:0] <= `ACS_REG_LAST;
	wire [2:0] wr_ofs_idx = wr_addr[4:2] - 3'd4;
	wire [2:0] rd_ofs_idx = s_axi_araddr[4:2] - 3'd4;
	wire cal_en_rise = ctrl[`ACS_CTRL_CAL_EN] & ~cal_en_q;
	// The core under calibration owns two adjacent trims, one per bank.
	wire [2:0] ofs_slot = swap_target == 2'd0 ? 3'd4 : {swap_target - 2'd1, 1'b0};

	always @(posedge clk) begin
		pin_s1 <= calibration_pin_trigger;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
	end

	// Write address and data may arrive in either order; each is held until both are present.
	always @(posedge clk) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ACS_RESP_OKAY;
			have_aw <= 1'b0;
			have_w <= 1'b0;
			wr_addr <= 32'h0000_0000;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			ctrl <= `ACS_CTRL_RESET;
			lp <= `ACS_LP_RESET;
			soft_pulse <= 1'b0;
		end else begin
			soft_pulse <= 1'b0;
			s_axi_awready <= ~have_aw & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~have_w & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_fire) begin
				have_aw <= 1'b0;
				have_w <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `ACS_RESP_OKAY;
				case (wr_addr[7:0])
					`ACS_REG_CTRL: begin
						if (wr_strb[0]) ctrl[7:0] <= wr_data[7:0];
						if (wr_strb[1]) ctrl[15:8] <= wr_data[15:8];
					end
					`ACS_REG_TRIG: begin
						soft_pulse <= wr_strb[0] & wr_data[0];
					end
					`ACS_REG_LP: begin
						if (wr_strb[0]) lp[7:0] <= wr_data[7:0];
						if (wr_strb[1]) lp[15:8] <= wr_data[15:8];
						if (wr_strb[2]) lp[23:16] <= wr_data[23:16];
						if (wr_strb[3]) lp[31:24] <= wr_data[31:24];
					end
					default: begin
						if (!wr_ofs_hit || wr_addr[1:0] != 2'b00) s_axi_bresp <= `ACS_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Offset trim writes are ignored while either offset enable bit is set, so software cannot corrupt them.
	// Each trim is its own register, so one process drives each byte.
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi = gi + 1) begin : g_trim
			reg [7:0] trim_value;
			always @(posedge clk) begin
				if (!rst_n) begin
					trim_value <= FACTORY_TRIM;
				end else if (offset_cal_active && count == 32'd1 && (state == S_FG_OFS
					|| (state == S_BG_CAL && (ofs_slot == gi || ofs_slot + 3'd1 == gi)))) begin
					trim_value <= ofs_estimate;
				end else if (wr_fire && wr_ofs_hit && wr_ofs_idx == gi && wr_strb[0]
					&& !any_ofs && wr_addr[1:0] == 2'b00) begin
					trim_value <= wr_data[7:0];
				end
			end
			assign input_offset_trim[gi * 8 +: 8] = trim_value;
		end
	endgenerate

	always @(posedge clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ACS_RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `ACS_RESP_OKAY;
				case (s_axi_araddr[7:0])
					`ACS_REG_CTRL: s_axi_rdata <= {16'h0000, ctrl[15:0]};
					`ACS_REG_TRIG: s_axi_rdata <= 32'h0000_0000;
					`ACS_REG_LP: s_axi_rdata <= lp;
					`ACS_REG_STATUS: s_axi_rdata <= {22'h0, offset_cal_active,
						swap_target, state};
					default: begin
						if (s_axi_araddr[7:0] >= `ACS_REG_OFS_BASE
							&& s_axi_araddr[7:0] <= `ACS_REG_LAST
							&& s_axi_araddr[1:0] == 2'b00) begin
							s_axi_rdata <= {24'h000000, input_offset_trim[rd_ofs_idx * 8 +: 8]};
						end else begin
							s_axi_rdata <= 32'h0000_0000;
							s_axi_rresp <= `ACS_RESP_SLVERR;
						end
					end
				endcase
				if (s_axi_araddr[7:0] == `ACS_REG_STATUS) begin
					s_axi_rdata[31] <= foreground_complete_flag;
				end
			end
		end
	end

	// Sequencer: foreground runs from reset, then background rotates core C through A and B.
	always @(posedge clk) begin
		if (!rst_n) begin
			state <= S_FG;
			count <= CAL_CYCLES;
			swap_target <= 2'd0;
			foreground_complete_flag <= 1'b0;
			fg_ofs_pending <= 1'b0;
			cal_en_q <= 1'b0;
			offset_cal_active <= 1'b0;
		end else begin
			cal_en_q <= ctrl[`ACS_CTRL_CAL_EN];
			if (count != 32'd0) count <= count - 32'd1;
			case (state)
				S_FG: begin
					if (count == 32'd1) begin
						state <= foreground_offset_enable ? S_FG_OFS : S_IDLE;
						offset_cal_active <= foreground_offset_enable;
						count <= OFS_CYCLES;
						if (!foreground_offset_enable) foreground_complete_flag <= 1'b1;
					end
				end
				S_FG_OFS: begin
					if (count == 32'd1) begin
						state <= S_IDLE;
						offset_cal_active <= 1'b0;
						foreground_complete_flag <= 1'b1;
						fg_ofs_pending <= 1'b0;
						// A one-time offset run in background mode hands straight on to the rotation.
						if (fg_ofs_pending && background_mode_enable) begin
							state <= low_power_spare_enable ? S_SETTLE : S_BG_CAL;
							count <= low_power_spare_enable ? {16'h0000, spare_settle_interval}
								: CAL_CYCLES;
							offset_cal_active <= background_offset_enable & ~low_power_spare_enable;
						end
					end
				end
				S_IDLE: begin
					if (trigger && background_mode_enable && !trigger_source_select) begin
						state <= low_power_spare_enable ? S_SETTLE : S_BG_CAL;
						count <= low_power_spare_enable ? {16'h0000, spare_settle_interval}
							: CAL_CYCLES;
						offset_cal_active <= background_offset_enable & ~low_power_spare_enable;
						if (fg_ofs_pending) begin
							state <= S_FG_OFS;
							offset_cal_active <= 1'b1;
							count <= OFS_CYCLES;
						end
					end else if (trigger && ctrl[`ACS_CTRL_CAL_EN]) begin
						state <= S_FG;
						count <= CAL_CYCLES;
						foreground_complete_flag <= 1'b0;
					end
				end
				S_SLEEP: begin
					if ((!spare_manual_switch && count <= 32'd1) || (spare_manual_switch && trigger)) begin
						state <= S_SETTLE;
						count <= {16'h0000, spare_settle_interval};
					end
				end
				S_SETTLE: begin
					if (count <= 32'd1) begin
						state <= S_BG_CAL;
						count <= CAL_CYCLES;
						offset_cal_active <= background_offset_enable;
					end
				end
				S_BG_CAL: begin
					if (count == 32'd1) begin
						swap_target <= swap_target == 2'd2 ? 2'd0 : swap_target + 2'd1;
						offset_cal_active <= 1'b0;
						if (!background_mode_enable) begin
							state <= S_IDLE;
						end else if (low_power_background_mode) begin
							state <= S_SLEEP;
							count <= {16'h0000, spare_sleep_interval};
						end else if (spare_manual_switch) begin
							state <= S_WAIT_SW;
						end else begin
							count <= CAL_CYCLES;
							offset_cal_active <= background_offset_enable;
						end
					end
				end
				S_WAIT_SW: begin
					if (!background_mode_enable) state <= S_IDLE;
					else if (trigger) begin
						state <= S_BG_CAL;
						count <= CAL_CYCLES;
						offset_cal_active <= background_offset_enable;
					end
				end
				default: state <= S_IDLE;
			endcase
			// After the case, so a fresh request wins over a clear in the same cycle.
			if (cal_en_rise && foreground_offset_enable) fg_ofs_pending <= 1'b1;
		end
	end

	// Core roles: swap_target 0 means C is the spare being calibrated, 1 C stands for A, 2 for B.
	// A swap retimes output selection in one cycle; small glitches at the seam are accepted.
	always @(posedge clk) begin
		if (!rst_n) begin
			data_out_a <= `ACS_MID_CODE;
			data_out_b <= `ACS_MID_CODE;
			core_online <= 3'b000;
			core_powered <= 3'b111;
			core_calibrating <= 3'b111;
			core_c_stands_for <= 2'd0;
			core_a_input <= 2'd0;
			core_b_input <= 2'd1;
		end else begin
			core_a_input <= ctrl[`ACS_CTRL_SINGLE] ? {1'b0, ctrl[`ACS_CTRL_IN_SEL]} : 2'd0;
			core_b_input <= ctrl[`ACS_CTRL_SINGLE] ? {1'b0, ctrl[`ACS_CTRL_IN_SEL]} : 2'd1;
			core_c_stands_for <= (state == S_FG || state == S_FG_OFS || state == S_IDLE) ?
				2'd0 : swap_target;
			if (state == S_FG || (state == S_FG_OFS && !background_mode_enable)) begin
				data_out_a <= `ACS_MID_CODE;
				data_out_b <= `ACS_MID_CODE;
				core_online <= 3'b000;
				core_calibrating <= 3'b111;
				core_powered <= 3'b111;
			end else if (state == S_IDLE || state == S_FG_OFS) begin
				data_out_a <= sample_core_a;
				data_out_b <= sample_core_b;
				core_online <= 3'b011;
				core_calibrating <= 3'b000;
				core_powered <= 3'b011 | {~low_power_spare_enable, 2'b00};
			end else begin
				data_out_a <= swap_target == 2'd1 ? sample_core_c : sample_core_a;
				data_out_b <= swap_target == 2'd2 ? sample_core_c : sample_core_b;
				core_online <= swap_target == 2'd1 ? 3'b110 : (swap_target == 2'd2 ? 3'b101 : 3'b011);
				core_calibrating <= state == S_BG_CAL ?
					(swap_target == 2'd1 ? 3'b001 : (swap_target == 2'd2 ? 3'b010 : 3'b100)) : 3'b000;
				core_powered <= state == S_SLEEP ?
					(swap_target == 2'd1 ? 3'b110 : (swap_target == 2'd2 ? 3'b101 : 3'b011)) : 3'b111;
			end
		end
	end
endmodule // acs_sequencer

// File: common/acs_consts.vh
// Constants for the converter calibration sequencer.
`ifndef ACS_CONSTS_VH
`define ACS_CONSTS_VH
`define ACS_REG_CTRL 8'h00
`define ACS_REG_TRIG 8'h04
`define ACS_REG_LP 8'h08
`define ACS_REG_STATUS 8'h0c
`define ACS_REG_OFS_BASE 8'h10
`define ACS_REG_LAST 8'h24
`define ACS_CTRL_CAL_EN 0
`define ACS_CTRL_BG 1
`define ACS_CTRL_TRIG_SRC 2
`define ACS_CTRL_FG_OFS 3
`define ACS_CTRL_BG_OFS 4
`define ACS_CTRL_LOW_POWER_SPARE_ENABLE 5
`define ACS_CTRL_MANUAL 6
`define ACS_CTRL_SINGLE 7
`define ACS_CTRL_IN_SEL 8
`define ACS_CTRL_RESET 32'h0000_0001
`define ACS_LP_RESET 32'h0010_0010
`define ACS_MID_CODE 8'h00
`define ACS_CAL_TIME_NS 1000
`define ACS_OFS_TIME_NS 500
`define ACS_CLK_NS 25
`define ACS_TRIM_DEFAULT 8'h80
`define ACS_RESP_OKAY 2'b00
`define ACS_RESP_SLVERR 2'b10
`endif

// File: test/acs_checker.sv
// Port assertions for the calibration sequencer.
`timescale 1ns/1ps
module acs_checker (
	input wire clk,
	input wire rst_n,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire [7:0] data_out_a,
	input wire [7:0] data_out_b,
	input wire [2:0] core_online,
	input wire [2:0] core_powered,
	input wire [2:0] core_calibrating,
	input wire [1:0] core_c_stands_for,
	input wire offset_cal_active
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// One cycle of slack lets the registered data path follow the calibrating flags.
	a_fg_mid_code: assert property ($past(core_calibrating) == 3'b111 &&
		core_calibrating == 3'b111 |-> core_online == 3'b000 && data_out_a == 8'h00
		&& data_out_b == 8'h00) else $error("output not mid-code in foreground");
	a_spare_online: assert property (core_c_stands_for != 2'd0 |-> core_online[2]
		&& core_c_stands_for != 2'd3) else $error("standing core not online");
	a_online_powered: assert property ((core_online & ~core_powered) == 3'b000)
		else $error("online core powered down");
	a_cal_powered: assert property ((core_calibrating & ~core_powered) == 3'b000)
		else $error("calibrating core powered down");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("write answer late");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held");
	c_fg: cover property (core_calibrating == 3'b111 ##1 core_calibrating == 3'b000);
	c_ofs: cover property (offset_cal_active);
	c_swap: cover property (core_c_stands_for == 2'd2);
endmodule // acs_checker
bind acs_sequencer acs_checker chk_u (.clk(clk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .data_out_a(data_out_a), .data_out_b(data_out_b),
	.core_online(core_online), .core_powered(core_powered),
	.core_calibrating(core_calibrating), .core_c_stands_for(core_c_stands_for),
	.offset_cal_active(offset_cal_active));

// File: test/acs_sequencer_tb_top.sv
// Self-checking bench for the calibration sequencer.
`timescale 1ns/1ps
`include "acs_consts.vh"
module acs_sequencer_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic pin = 1'b0;
	logic [7:0] sa = 8'h00, sb = 8'h00, sc = 8'h00, ofs = 8'h00;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] rsp;
	wire awready, wready, bvalid, arready, rvalid, pwr_unused;
	wire [1:0] bresp, rresp, c_for, a_in, b_in;
	wire [31:0] rdata;
	wire [7:0] out_a, out_b;
	wire [2:0] online, powered, calib;
	wire ofs_act;
	int fails = 0;
	int n_compared = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		sa <= ofs_act ? 8'h00 : 8'($urandom);
		sb <= ofs_act ? 8'h00 : 8'($urandom);
		sc <= ofs_act ? 8'h00 : 8'($urandom);
	end
	acs_sequencer dut_u (.clk(clk), .rst_n(rst_n), .calibration_pin_trigger(pin),
		.sample_core_a(sa), .sample_core_b(sb), .sample_core_c(sc), .ofs_estimate(ofs),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_out_a(out_a),
		.data_out_b(out_b), .core_online(online), .core_powered(powered),
		.core_calibrating(calib), .core_c_stands_for(c_for), .core_a_input(a_in),
		.core_b_input(b_in), .offset_cal_active(ofs_act));
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task hang;
		fails++;
		$display("[FAIL] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
		complete_run;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
			if (awready && awvalid) awvalid <= 1'b0;
			if (wready && wvalid) wvalid <= 1'b0;
		end while (!(bvalid && bready) && k < 200);
		if (k >= 200) hang;
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task axr(input logic [7:0] a);
		int k;
		@(posedge clk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
			if (arready && arvalid) arvalid <= 1'b0;
		end while (!rvalid && k < 200);
		if (k >= 200) hang;
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	// The flag is polled over the bus, so a foreground run must outlast a few reads.
	task wait_done(input logic v);
		int k;
		k = 0;
		do begin
			axr(`ACS_REG_STATUS);
			k++;
		end while (rd[31] !== v && k < 400);
		if (rd[31] !== v) hang;
	endtask
	task wait_state(input logic [6:0] s);
		int k;
		k = 0;
		do begin
			axr(`ACS_REG_STATUS);
			k++;
		end while (rd[6:0] !== s && k < 100);
		if (rd[6:0] !== s) hang;
		check(rd[6:0], s);
	endtask
	function logic [31:0] port(input int w);
		case (w)
			0: return c_for;
			1: return ofs_act;
			default: return powered[2];
		endcase
	endfunction
	task wait_port(input int w, input int v);
		int k;
		for (k = 0; k < 3000 && port(w) !== v; k++) @(posedge clk);
		if (port(w) !== v) hang;
	endtask
	function logic [31:0] ctrl_of(input int m);
		return 32'h1 | ((m == 1 || m == 2) ? 32'h80 : 32'h0) | ((m == 2) ? 32'h100 : 32'h0)
			| ((m == 3) ? 32'h4 : 32'h0);
	endfunction
	function logic [3:0] exp_in(input int m);
		return (m == 1) ? 4'h0 : (m == 2) ? 4'h5 : 4'h1;
	endfunction
	initial begin
		logic [31:0] v;
		void'($urandom(58377));
		ofs <= $urandom;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		axr(`ACS_REG_STATUS);
		check(rd[31], 1'b0);
		wait_done(1'b1);
		axr(`ACS_REG_CTRL);
		check(rd, `ACS_CTRL_RESET);
		axr(`ACS_REG_LP);
		check(rd, `ACS_LP_RESET);
		$display("test power-up done");
		for (int i = 0; i < 6; i++) begin
			v = $urandom;
			axr(`ACS_REG_OFS_BASE + 4 * i);
			check(rd[7:0], `ACS_TRIM_DEFAULT);
			axw(`ACS_REG_OFS_BASE + 4 * i, v);
			axr(`ACS_REG_OFS_BASE + 4 * i);
			check(rd[7:0], v[7:0]);
		end
		axr(8'h28);
		check(rd, 32'h0);
		check(rsp, `ACS_RESP_SLVERR);
		axr(8'h02);
		check(rsp, `ACS_RESP_SLVERR);
		axw(8'h28, 32'h5);
		check(rsp, `ACS_RESP_SLVERR);
		$display("test trims done");
		for (int m = 0; m < 4; m++) begin
			axw(`ACS_REG_CTRL, ctrl_of(m));
			if (m == 3) begin
				@(posedge clk);
				pin <= 1'b1;
				repeat (4) @(posedge clk);
				pin <= 1'b0;
			end else
				axw(`ACS_REG_TRIG, 32'h1);
			wait_done(1'b0);
			check(online, 3'b000);
			check({out_a, out_b}, 16'h0000);
			wait_done(1'b1);
			check({a_in, b_in}, exp_in(m));
			@(posedge clk);
			v = {sa, sb, 16'h0000};
			@(posedge clk);
			check({out_a, out_b}, v[31:16]);
		end
		$display("test foreground done");
		axw(`ACS_REG_CTRL, 32'h9);
		axw(`ACS_REG_TRIG, 32'h1);
		wait_port(1, 1);
		wait_done(1'b1);
		axw(`ACS_REG_OFS_BASE, {24'h0, ~ofs});
		axr(`ACS_REG_OFS_BASE);
		check(rd[7:0], ofs);
		$display("test offset done");
		axw(`ACS_REG_CTRL, 32'h3);
		axw(`ACS_REG_TRIG, 32'h1);
		wait_port(0, 1);
		wait_port(0, 2);
		check(online[2], 1'b1);
		axw(`ACS_REG_CTRL, 32'h13);
		wait_port(1, 1);
		axw(`ACS_REG_LP, 32'h0004_0008);
		axr(`ACS_REG_LP);
		check(rd, 32'h0004_0008);
		axw(`ACS_REG_CTRL, 32'h23);
		wait_port(2, 0);
		wait_port(2, 1);
		$display("test background done");
		axw(`ACS_REG_CTRL, 32'h0);
		wait_state(7'h04);
		ofs <= ~ofs;
		axw(`ACS_REG_CTRL, 32'h8);
		axw(`ACS_REG_CTRL, 32'hb);
		axw(`ACS_REG_TRIG, 32'h1);
		wait_port(1, 1);
		wait_port(1, 0);
		wait_state(7'h20);
		axr(`ACS_REG_OFS_BASE + 8'h0c);
		check(rd[7:0], ofs);
		axw(`ACS_REG_CTRL, 32'h4b);
		wait_state(7'h40);
		repeat (100) @(posedge clk);
		axr(`ACS_REG_STATUS);
		check(rd[6:0], 7'h40);
		axw(`ACS_REG_TRIG, 32'h1);
		wait_state(7'h20);
		$display("test one-time offset and manual switch done");
		complete_run;
	end
endmodule // acs_sequencer_tb_top
